// file: core/llpc_pkg.sv
// llpc_pkg: register map, reset values and carrier types of the led link and polarity control block
// assumes an 8-bit register port with byte offsets as printed
package llpc_pkg;
   localparam int unsigned LLPC_CHANNELS   = 11;
   localparam logic [7:0]  LLPC_POL_LO_OFF = 8'h75;
   localparam logic [7:0]  LLPC_POL_HI_OFF = 8'h76;
   localparam logic [7:0]  LLPC_TRN_LO_OFF = 8'h77;
   localparam logic [7:0]  LLPC_TRN_HI_OFF = 8'h78;
   localparam logic [7:0]  LLPC_MIR_LO_OFF = 8'h79;
   localparam logic [7:0]  LLPC_MIR_HI_OFF = 8'h7a;
   localparam logic [7:0]  LLPC_LINK_OFF   = 8'h80;
   localparam logic [7:0]  LLPC_RESET_VAL  = 8'h00;
   localparam logic [7:0]  LLPC_HI3_MASK   = 8'h07;
   localparam logic [7:0]  LLPC_HI2_MASK   = 8'h03;
   localparam logic [7:0]  LLPC_TRN_LO_MSK = 8'h7f;
   localparam int unsigned LLPC_UPDN_BIT   = 7;
   localparam int unsigned LLPC_CH9        = 8;   // zero-based index of channel nine
   localparam int unsigned LLPC_CH10       = 9;

   // register port access
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } llpc_bus_s;

   // group slider events
   typedef struct packed {
      logic up_evt;
      logic down_evt;
   } llpc_group_s;

   typedef enum logic [0:0] {
      LLPC_GRP_IDLE = 1'b0,
      LLPC_GRP_HELD = 1'b1
   } llpc_grp_e;
endpackage

// file: core/llpc_regs.sv
// llpc_regs: small byte-wide register store with registered read data
// assumes one access per cycle; writes masked per entry by the caller
`timescale 1ns/1ps
`default_nettype none
module llpc_regs
   import llpc_pkg::*;
#(
   parameter int unsigned DEPTH = 7
) (
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
   input  wire logic [7:0]               wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output logic      [7:0]               rd_data,
   output logic      [DEPTH*8-1:0]       flat
);
   logic [7:0] mem_reg  [DEPTH];
   logic [7:0] mem_next [DEPTH];
   logic [7:0] rd_next;

   // next state of the store and read port
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_next[i] = mem_reg[i];
      end
      if (wr_en) begin
         mem_next[wr_idx] = wr_data;
      end
      rd_next = mem_reg[rd_idx];
   end

   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_reg[i] <= rst ? LLPC_RESET_VAL : mem_next[i];
      end
      rd_data <= rst ? LLPC_RESET_VAL : rd_next;
   end

   // flat view for the control logic
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         flat[i*8 +: 8] = mem_reg[i];
      end
   end
endmodule
`default_nettype wire

// file: core/llpc_top.sv
// llpc_top: polarity, mirror, linked transition and sensor link control for eleven led channels
// assumes touch and group events arrive synchronous to ref_clk from the touch detector
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - polarity bit 0 inverts: request one drives the pin low
// - polarity bit 1: request one drives high or releases an open-drain pin
// - polarity channels 1-8 at bits 0-7 of low, 9-11 at bits 0-2 of high
// - transition bits act only while linked, combined with global inverted transition
// - transition 0, request one, link without touch: led changes state
// - transition 1, inverted 1: linking keeps state, touches then toggle it
// - transition 1, inverted 0: linking keeps state, touches change nothing
// - transition channels 1-7 bits 0-6 low, channels 9-10 bits 0-1 high
// - mirror 0 means duty relative to 0%, 1 relative to 100%
// - polarity writes copy into mirror bits unless block mirror update set
// - mirror channels 1-8 bits 0-7 low, 9-11 bits 0-2 high
// - link bit set makes led follow its sensor instead of host
// - link bit ignored when the channel pin is an input
// - link bit 7: group up actuates channel ten, down channel nine
// - channels nine and ten never active together while linked with their transition bits clear
// - link clear: touch ignored, led follows its request bit
// - link set: touch actuates led and output enables automatically
// - sensor n to led n link at bit n-1, n one to seven
// - linked touch counts exactly as request bit one for pin drive
module llpc_top
   import llpc_pkg::*;
#(
   parameter int unsigned NCH = LLPC_CHANNELS
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire llpc_bus_s         bus,
   output logic      [7:0]        rdata,
   input  wire logic [NCH-1:0]    channel_output_request,
   input  wire logic [NCH-1:0]    channel_is_input,
   input  wire logic [NCH-1:0]    channel_open_drain,
   input  wire logic [6:0]        touch_sensor_n,
   input  wire llpc_group_s       group_evt,
   input  wire logic              global_inverted_link_transition,
   input  wire logic              block_polarity_mirror_update,
   output logic      [NCH-1:0]    channel_actuate,
   output logic      [NCH-1:0]    channel_duty_mirror,
   output logic      [NCH-1:0]    channel_output_enable,
   output logic      [NCH-1:0]    pin_out,
   output logic      [NCH-1:0]    pin_oe_n
);
   localparam int unsigned NREG = 7;
   localparam int unsigned IW   = 3;

   logic [IW-1:0]     wr_idx;
   logic [IW-1:0]     rd_idx;
   logic              hit;
   logic              wr_en;
   logic [7:0]        wr_data;
   logic [7:0]        rd_raw;
   logic [NREG*8-1:0] flat;
   logic [7:0]        pol_lo, pol_hi, trn_lo, trn_hi, mir_lo, mir_hi, link;
   logic              rd_hit_reg, rd_hit_next;
   logic              mir_copy_lo, mir_copy_hi;
   logic [7:0]        copy_data;
   logic [IW:0]       dec;

   // maps printed offsets to store index
   function automatic logic [IW:0] llpc_decode(input logic [7:0] a);
      case (a)
         LLPC_POL_LO_OFF: llpc_decode = {1'b1, 3'h0};
         LLPC_POL_HI_OFF: llpc_decode = {1'b1, 3'h1};
         LLPC_TRN_LO_OFF: llpc_decode = {1'b1, 3'h2};
         LLPC_TRN_HI_OFF: llpc_decode = {1'b1, 3'h3};
         LLPC_MIR_LO_OFF: llpc_decode = {1'b1, 3'h4};
         LLPC_MIR_HI_OFF: llpc_decode = {1'b1, 3'h5};
         LLPC_LINK_OFF:   llpc_decode = {1'b1, 3'h6};
         default:         llpc_decode = 4'h0;
      endcase
   endfunction

   // masks reserved bits so they always read zero
   function automatic logic [7:0] llpc_mask(input logic [IW-1:0] i, input logic [7:0] d);
      case (i)
         3'h1, 3'h5: llpc_mask = d & LLPC_HI3_MASK;
         3'h2:       llpc_mask = d & LLPC_TRN_LO_MSK;
         3'h3:       llpc_mask = d & LLPC_HI2_MASK;
         default:    llpc_mask = d;
      endcase
   endfunction

   // register port decode; a polarity write also copies into mirror, one cycle later
   always_comb begin
      dec     = llpc_decode(bus.addr);
      hit     = dec[IW];
      wr_idx  = dec[IW-1:0];
      rd_idx  = wr_idx;
      wr_en   = bus.wr & hit;
      wr_data = llpc_mask(wr_idx, bus.wdata);
      rd_hit_next = bus.rd & hit;
      if (mir_copy_lo | mir_copy_hi) begin
         // pending mirror copy takes the store port; a host write in that cycle is lost
         wr_en   = 1'b1;
         wr_idx  = mir_copy_lo ? 3'h4 : 3'h5;
         wr_data = copy_data;
      end
   end

   logic mir_copy_lo_next, mir_copy_hi_next;
   logic [7:0] copy_next;
   // schedule the mirror copy after a polarity write
   always_comb begin
      mir_copy_lo_next = bus.wr & hit & (wr_idx == 3'h0) & ~block_polarity_mirror_update
                         & ~(mir_copy_lo | mir_copy_hi);
      mir_copy_hi_next = bus.wr & hit & (wr_idx == 3'h1) & ~block_polarity_mirror_update
                         & ~(mir_copy_lo | mir_copy_hi);
      copy_next        = wr_data;
   end

   always_ff @(posedge ref_clk) begin
      mir_copy_lo <= rst ? 1'b0 : mir_copy_lo_next;
      mir_copy_hi <= rst ? 1'b0 : mir_copy_hi_next;
      copy_data   <= rst ? LLPC_RESET_VAL : copy_next;
      rd_hit_reg  <= rst ? 1'b0 : rd_hit_next;
   end

   llpc_regs #(.DEPTH(NREG)) u_regs (
      .ref_clk (ref_clk),
      .rst     (rst),
      .wr_en   (wr_en),
      .wr_idx  (wr_idx),
      .wr_data (wr_data),
      .rd_idx  (rd_idx),
      .rd_data (rd_raw),
      .flat    (flat)
   );

   // unmapped reads return zero
   assign rdata = rd_hit_reg ? rd_raw : 8'h00;

   assign pol_lo = flat[7:0];
   assign pol_hi = flat[15:8];
   assign trn_lo = flat[23:16];
   assign trn_hi = flat[31:24];
   assign mir_lo = flat[39:32];
   assign mir_hi = flat[47:40];
   assign link   = flat[55:48];

   logic [NCH-1:0] pol, mir, trn, lnk, touch;
   // per-channel views of the fields
   always_comb begin
      pol = {pol_hi[2:0], pol_lo};
      mir = {mir_hi[2:0], mir_lo};
      trn = {1'b0, trn_hi[1:0], 1'b0, trn_lo[6:0]};
      lnk = {1'b0, {2{link[LLPC_UPDN_BIT]}}, 1'b0, link[6:0]} & ~channel_is_input;
      touch = '0;
      touch[6:0] = touch_sensor_n;
   end

   assign channel_duty_mirror = mir;

   // group latch: last event holds its channel, the other is forced off
   llpc_grp_e grp_reg, grp_next;
   logic      grp_up_reg, grp_up_next;
   always_comb begin
      grp_next    = grp_reg;
      grp_up_next = grp_up_reg;
      if (!link[LLPC_UPDN_BIT]) begin
         grp_next = LLPC_GRP_IDLE;
      end else if (group_evt.up_evt) begin
         grp_next    = LLPC_GRP_HELD;
         grp_up_next = 1'b1;
      end else if (group_evt.down_evt) begin
         grp_next    = LLPC_GRP_HELD;
         grp_up_next = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      grp_reg    <= rst ? LLPC_GRP_IDLE : grp_next;
      grp_up_reg <= rst ? 1'b0 : grp_up_next;
   end

   // group channels behave like sensors
   logic [NCH-1:0] sense;
   always_comb begin
      sense = touch;
      sense[LLPC_CH10] = (grp_reg == LLPC_GRP_HELD) & grp_up_reg;
      sense[LLPC_CH9]  = (grp_reg == LLPC_GRP_HELD) & ~grp_up_reg;
   end

   // linked transition state: keep host state at link time and optionally toggle on touch
   logic [NCH-1:0] lnk_d_reg, held_reg, held_next, sense_d_reg;
   always_comb begin
      held_next = held_reg;
      for (int i = 0; i < NCH; i++) begin
         if (lnk[i] & ~lnk_d_reg[i]) begin
            held_next[i] = channel_output_request[i];
         end else if (lnk[i] & trn[i] & global_inverted_link_transition
                      & sense[i] & ~sense_d_reg[i]) begin
            held_next[i] = ~held_reg[i];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      lnk_d_reg   <= rst ? '0 : lnk;
      held_reg    <= rst ? '0 : held_next;
      sense_d_reg <= rst ? '0 : sense;
   end

   // actuation source per channel, then polarity at the pin
   logic [NCH-1:0] act_next, out_next, oe_n_next, en_next;
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         if (!lnk[i]) begin
            act_next[i] = channel_output_request[i];
         end else if (!trn[i]) begin
            act_next[i] = sense[i];
         end else begin
            // transition set: held value either toggles or stays fixed
            act_next[i] = held_next[i];
         end
         out_next[i]  = pol[i] ? act_next[i] : ~act_next[i];
         oe_n_next[i] = channel_is_input[i] | (channel_open_drain[i] & out_next[i]);
         en_next[i]   = lnk[i];
      end
   end

   always_ff @(posedge ref_clk) begin
      channel_actuate       <= rst ? '0 : act_next;
      pin_out               <= rst ? '0 : out_next;
      pin_oe_n              <= rst ? '1 : oe_n_next;
      channel_output_enable <= rst ? '0 : en_next;
   end

   // group pair never both actuated while linked with their transition bits clear
   group_exclusive_a: assert property (@(posedge ref_clk) disable iff (rst)
      !(channel_actuate[LLPC_CH9] && channel_actuate[LLPC_CH10] && link[LLPC_UPDN_BIT]
        && (trn[LLPC_CH9] == 1'b0) && (trn[LLPC_CH10] == 1'b0)))
      else $error("group channels active together");
   inverted_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
      !pol[0] && !lnk[0] |=> pin_out[0] == ~$past(channel_output_request[0]))
      else $error("inverted polarity drive wrong");
   noninv_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
      pol[0] && !lnk[0] |=> pin_out[0] == $past(channel_output_request[0]))
      else $error("non-inverted drive wrong");
   mirror_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
      bus.wr && bus.addr == LLPC_POL_LO_OFF && !block_polarity_mirror_update && !mir_copy_lo
      && !mir_copy_hi |-> ##2 mir_lo == $past(bus.wdata, 2))
      else $error("mirror not copied from polarity");
   unlinked_touch_a: assert property (@(posedge ref_clk) disable iff (rst)
      !lnk[1] |=> channel_actuate[1] == $past(channel_output_request[1]))
      else $error("unlinked channel followed touch");
   linked_touch_a: assert property (@(posedge ref_clk) disable iff (rst)
      lnk[2] && !trn[2] |=> channel_actuate[2] == $past(touch_sensor_n[2]))
      else $error("linked channel ignored touch");
   input_ignored_a: assert property (@(posedge ref_clk) disable iff (rst)
      channel_is_input[3] |=> !channel_output_enable[3])
      else $error("input channel enabled by link");
   hold_fixed_a: assert property (@(posedge ref_clk) disable iff (rst)
      lnk[4] && $past(lnk[4]) && trn[4] && $past(trn[4]) && !global_inverted_link_transition
      |=> $stable(channel_actuate[4]))
      else $error("fixed transition changed");
   up_event_a: assert property (@(posedge ref_clk) disable iff (rst)
      link[LLPC_UPDN_BIT] && group_evt.up_evt |=> sense[LLPC_CH10] && !sense[LLPC_CH9])
      else $error("up event did not select channel ten");
endmodule
`default_nettype wire

// file: tb/llpc_far_side.sv
// llpc_far_side: touch detector and led pins outside the control block
// assumes bench commands change just after ref_clk edges; pins have pull-ups
`timescale 1ns/1ps
`default_nettype none
module llpc_far_side
   import llpc_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [6:0]  touch_cmd,
   input  wire llpc_group_s grp_cmd,
   input  wire logic [10:0] pin_out,
   input  wire logic [10:0] pin_oe_n,
   output llpc_group_s      group_evt,
   output logic      [6:0]  touch_sensor_n,
   output logic      [10:0] pin_level
);
   // detector outputs are registered, so touches land one cycle late
   always_ff @(posedge ref_clk) begin
      touch_sensor_n <= rst ? 7'h00 : touch_cmd;
      group_evt      <= rst ? '0 : grp_cmd;
   end
   // a released pin floats to the pull-up, never to the last driven value
   assign pin_level = pin_out | pin_oe_n;
endmodule
`default_nettype wire

// file: tb/tb_llpc_top.sv
// tb_llpc_top: register, polarity, mirror, transition and link checks
// assumes the far side model stands in for touch detector and led pins
`timescale 1ns/1ps
`default_nettype none
module tb_llpc_top;
   import llpc_pkg::*;
   localparam logic [2:0] K_RD = 3'h1, K_ACT = 3'h2, K_LVL = 3'h3, K_EN = 3'h4, K_MIR = 3'h5, K_OEN = 3'h6;
   logic        ref_clk;
   logic        rst;
   llpc_bus_s   bus;
   logic [7:0]  rdata;
   logic [10:0] req, is_in, od, act, mir, en, pout, poe_n, lvl, r, a, p, exp_v, seen;
   logic [6:0]  touch_cmd, touch, t;
   llpc_group_s grp_cmd, grp;
   logic        inv_tran;
   logic        blk_mir;
   logic [2:0]  probe;
   logic [10:0] notes[$];
   logic [31:0] seed = 32'h435db637;
   logic [31:0] w;
   logic [7:0]  v[7];
   logic [7:0]  offs[7] = '{LLPC_POL_LO_OFF, LLPC_POL_HI_OFF, LLPC_TRN_LO_OFF, LLPC_TRN_HI_OFF,
                            LLPC_MIR_LO_OFF, LLPC_MIR_HI_OFF, LLPC_LINK_OFF};
   logic [7:0]  msks[7] = '{8'hff, LLPC_HI3_MASK, LLPC_TRN_LO_MSK, LLPC_HI2_MASK, 8'hff, LLPC_HI3_MASK, 8'hff};
   string       names[7] = '{"none", "rdata", "actuate", "pin level", "enable", "mirror", "oe_n"};
   int          bad_count;
   int          checked;

   llpc_top i_llpc_top (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata), .channel_output_request(req),
      .channel_is_input(is_in), .channel_open_drain(od), .touch_sensor_n(touch), .group_evt(grp),
      .global_inverted_link_transition(inv_tran), .block_polarity_mirror_update(blk_mir),
      .channel_actuate(act), .channel_duty_mirror(mir), .channel_output_enable(en), .pin_out(pout),
      .pin_oe_n(poe_n));
   llpc_far_side i_llpc_far_side (.ref_clk(ref_clk), .rst(rst), .touch_cmd(touch_cmd), .grp_cmd(grp_cmd),
      .pin_out(pout), .pin_oe_n(poe_n), .group_evt(grp), .touch_sensor_n(touch), .pin_level(lvl));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // flag an output for the monitor; one cycle per note keeps the queue in step
   task automatic note(input logic [2:0] k, input logic [10:0] e);
      notes.push_back(e);
      probe <= k;
      @(posedge ref_clk);
      probe <= 3'h0;
   endtask
   // the idle cycle after each write protects the polarity copy cycle
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge ref_clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
      @(posedge ref_clk);
      bus.wr <= 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [7:0] e);
      @(posedge ref_clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      note(K_RD, {3'h0, e});
   endtask
   task automatic pins(input logic [10:0] ea, input logic [10:0] el, input logic [10:0] ee);
      tick(3);
      note(K_ACT, ea);
      note(K_LVL, el);
      note(K_EN, ee);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // compare at the falling edge, where registered outputs have settled
   always @(negedge ref_clk) begin
      if (probe != 3'h0) begin
         exp_v = notes.pop_front();
         case (probe)
            K_RD:    seen = {3'h0, rdata};
            K_ACT:   seen = act;
            K_LVL:   seen = lvl;
            K_EN:    seen = en;
            K_MIR:   seen = mir;
            default: seen = poe_n;
         endcase
         checked++;
         if (seen !== exp_v) begin
            bad_count++;
            $display("Error %s expected %h seen %h", names[probe], exp_v, seen);
         end
      end
   end
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // whole run is about 300 cycles; this limit only catches a hang
   initial begin
      #200us;
      bad_count++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      bus = '0;
      req = '0;
      is_in = '0;
      od = '0;
      touch_cmd = '0;
      grp_cmd = '0;
      inv_tran = 1'b0;
      blk_mir = 1'b0;
      probe = 3'h0;
      tick(20);
      rst <= 1'b0;
      foreach (offs[i]) rd(offs[i], LLPC_RESET_VAL);
      rd(8'h7b, 8'h00);
      // random fill with the mirror copy blocked, then read back through masks
      blk_mir <= 1'b1;
      foreach (offs[i]) begin
         v[i] = 8'(rnd());
         wr(offs[i], v[i]);
      end
      foreach (offs[i]) rd(offs[i], v[i] & msks[i]);
      wr(LLPC_POL_LO_OFF, ~v[4]);
      rd(LLPC_MIR_LO_OFF, v[4]);
      blk_mir <= 1'b0;
      wr(LLPC_POL_LO_OFF, v[1]);
      wr(LLPC_POL_HI_OFF, v[2]);
      rd(LLPC_MIR_LO_OFF, v[1]);
      note(K_MIR, {v[2][2:0], v[1]});
      // random links, polarities, requests and touches with transition bits clear
      wr(LLPC_TRN_LO_OFF, 8'h00);
      wr(LLPC_TRN_HI_OFF, 8'h00);
      repeat (8) begin
         w = rnd();
         r = 11'(rnd());
         t = 7'(rnd());
         p = {w[18:16], w[15:8]};
         wr(LLPC_LINK_OFF, {1'b0, w[6:0]});
         wr(LLPC_POL_LO_OFF, p[7:0]);
         wr(LLPC_POL_HI_OFF, {5'h0, p[10:8]});
         req <= r;
         touch_cmd <= t;
         od <= 11'(rnd());
         a = {r[10:7], (w[6:0] & t) | (~w[6:0] & r[6:0])};
         pins(a, ~(a ^ p), {4'h0, w[6:0]});
      end
      // channel one: link with no touch while its request is one
      req <= 11'h001;
      touch_cmd <= 7'h00;
      wr(LLPC_LINK_OFF, 8'h00);
      tick(3);
      note(K_ACT, 11'h001);
      wr(LLPC_LINK_OFF, 8'h01);
      tick(3);
      note(K_ACT, 11'h000);
      touch_cmd <= 7'h01;
      tick(3);
      note(K_ACT, 11'h001);
      note(K_EN, 11'h001);
      wr(LLPC_TRN_LO_OFF, 8'h01);
      for (int k = 1; k >= 0; k--) begin
         inv_tran <= k[0];
         touch_cmd <= 7'h00;
         wr(LLPC_LINK_OFF, 8'h00);
         wr(LLPC_LINK_OFF, 8'h01);
         tick(3);
         note(K_ACT, 11'h001);
         touch_cmd <= 7'h01;
         tick(3);
         note(K_ACT, {10'h0, ~k[0]});
      end
      // an input pin ignores its link and is never driven
      od <= 11'h000;
      is_in <= 11'h001;
      wr(LLPC_TRN_LO_OFF, 8'h00);
      tick(3);
      note(K_EN, 11'h000);
      note(K_OEN, 11'h001);
      is_in <= 11'h000;
      // group up then down, each checked before the next event
      req <= 11'h000;
      wr(LLPC_LINK_OFF, 8'h80);
      for (int k = 0; k < 2; k++) begin
         grp_cmd <= '{up_evt: k == 0, down_evt: k == 1};
         @(posedge ref_clk);
         grp_cmd <= '0;
         tick(3);
         note(K_ACT, (k == 0) ? 11'h200 : 11'h100);
      end
      conclude();
   end
endmodule
`default_nettype wire
